// *** hw/adc_seq_defs.svh ***
// Purpose: register map, field positions, reset values and timing constants
// Assumes: 8-bit register port, byte offsets as printed
// Notes: definitions only
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CTL_ADDR 8'h30
`define RES1_ADDR 8'h31
`define RES4_ADDR 8'h34
`define OPT_ADDR 8'h39

// ------------------------------------------------------------
// control/status fields
// ------------------------------------------------------------
`define CTL_FLAG_BIT 7
`define CTL_REPEAT_BIT 5
`define CTL_MULTI_BIT 4
`define CTL_WR_MASK 8'h3f
`define CTL_CHAN_MSB 3
`define CTL_GROUP_LSB 2

// ------------------------------------------------------------
// options fields
// ------------------------------------------------------------
`define OPT_RESET 8'h10
`define OPT_PROT_MASK 8'h37
`define OPT_PU_BIT 7
`define OPT_CONV_CLOCK_SELECT_BIT 6
`define OPT_IRQ_EDGE_SELECT_BIT 5
`define OPT_DLY_BIT 4
`define OPT_CME_BIT 3
`define OPT_CLOCK_MONITOR_FORCE_BIT 2
`define OPT_RATE_MSB 1
`define PROT_WINDOW 7'h40

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CORE_PERIOD_PS 8000
`define E_PERIOD_PS 500000
`define SAMPLE_TICKS 4'hc
`define LAST_SLOT 2'h3
`define SAR_MSB 3'h7
`define SAR_START 8'h80

`endif

// *** hw/adc_seq_pkg.sv ***
// Purpose: types shared by the converter sequencer
// Assumes: constants come from adc_seq_defs.svh
// Notes: all sequencer state lives in seq_state_t
package adc_seq_pkg;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ARM,
        PH_SAMPLE,
        PH_COMPARE
    } phase_t;

    typedef struct packed {
        logic [3:0] channel;
        logic sample;
        logic [7:0] dac_code;
        logic powered;
        logic use_rc_clock;
    } analog_ctl_t;

    typedef struct packed {
        logic irq_falling_edge;
        logic startup_delay_enable;
        logic clock_monitor_on;
        logic [1:0] watchdog_rate_select;
    } sys_opts_t;

    typedef struct packed {
        phase_t phase;
        logic [7:0] ctl;
        logic [3:0][7:0] results;
        logic [7:0] opt;
        logic force_latched;
        logic [6:0] win_cnt;
        logic prot_used;
        logic [1:0] slot;
        logic [3:0] tick_cnt;
        logic [2:0] bit_idx;
        logic [7:0] sar;
        logic pend_valid;
        logic [1:0] pend_slot;
        logic [7:0] pend_data;
        logic [7:0] ediv;
        logic [7:0] rd_data;
    } seq_state_t;

endpackage : adc_seq_pkg

// *** hw/adc_conversion_sequencer.sv ***
// Purpose: digital control and sequencing of an 8-bit successive-approximation converter
// Assumes: all inputs synchronous to core_clk_in; rc_tick_in is a one-cycle pulse
// Notes: analog mux, comparator and capacitor array sit outside this block
//
// The address-and-strobe port was decided locally.
`include "adc_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// [R1] four 8-bit results, readable, flag marks validity
// [R2] results commit only in cycles without read
// [R3] clock select: 1 rc tick, 0 e clock
// [R4] sequences of four, repeat or single pass
// [R5] flag set when fourth result lands
// [R6] sequence starts one e clock after write
// [R7] low reference 00, high ff, no overflow
// [R8] power-up bit enables converter, clear disables
// [R9] software waits 100us after power-up
// [R10] e clock mode samples on quiet ticks
// [R11] protected option bits: one write, 64 cycles
// [R12] irq edge bit: 1 falling, 0 level
// [R13] delay bit selects start-up stabilisation delay
// [R14] force bit holds clock monitor until reset
// [R15] sixteen mux sources selected by channel code
// [R16] single no repeat: four conversions then halt
// [R17] single repeat: results wrap cyclically
// [R18] multi no repeat: group once then halt
// [R19] multi repeat: group cycles, results replaced
// [R20] control layout: flag, zero, repeat, multi, channel
// [R21] control write aborts and restarts sequence
// [R22] control write clears completion flag
// [R23] multi mode uses upper two channel bits
// [R24] group converted in ascending channel order
module adc_conversion_sequencer #(
    parameter int E_DIV = `E_PERIOD_PS / `CORE_PERIOD_PS
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rd_data_out,
    input wire logic special_mode_in,
    input wire logic rc_tick_in,
    input wire logic comparator_in,
    output adc_seq_pkg::analog_ctl_t analog_ctl_out,
    output adc_seq_pkg::sys_opts_t sys_opts_out,
    output logic e_tick_out,
    output logic sequence_complete_flag_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    adc_seq_pkg::seq_state_t s;
    adc_seq_pkg::seq_state_t next_s;

    logic e_tick;
    logic conv_tick;
    logic ctl_write;
    logic opt_write;
    logic prot_open;
    logic repeat_mode;
    logic multi_mode;
    logic [3:0] chan;

    localparam logic [7:0] E_LAST = 8'(E_DIV - 1);

    // ------------------------------------------------------------
    // timing sources
    // ------------------------------------------------------------
    assign e_tick = (s.ediv == E_LAST);
    // rc ticks are not aligned to the e clock, so accuracy is a bit lower there
    assign conv_tick = s.opt[`OPT_CONV_CLOCK_SELECT_BIT] ? rc_tick_in : e_tick; // [R3] [R10]

    assign ctl_write = wr_in && (addr_in == `CTL_ADDR);
    assign opt_write = wr_in && (addr_in == `OPT_ADDR);
    assign prot_open = special_mode_in || (!s.prot_used && (s.win_cnt < `PROT_WINDOW));

    assign repeat_mode = s.ctl[`CTL_REPEAT_BIT];
    assign multi_mode = s.ctl[`CTL_MULTI_BIT];

    // ------------------------------------------------------------
    // channel steering
    // ------------------------------------------------------------
    always_comb begin
        if (multi_mode) begin
            chan = {s.ctl[`CTL_CHAN_MSB:`CTL_GROUP_LSB], s.slot}; // [R23] [R24]
        end else begin
            chan = s.ctl[`CTL_CHAN_MSB:0]; // [R15] [R16] [R17]
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;

        // e clock divider, free running
        if (e_tick) begin
            next_s.ediv = 8'h00;
        end else begin
            next_s.ediv = s.ediv + 8'h01;
        end

        // protection window counts core cycles after reset and then saturates
        if (s.win_cnt < `PROT_WINDOW) begin
            next_s.win_cnt = s.win_cnt + 7'h01;
        end

        // deferred result commit, held off while a read is in progress
        if (s.pend_valid && !rd_in) begin
            next_s.results[s.pend_slot] = s.pend_data; // [R1] [R2]
            next_s.pend_valid = 1'b0;
            if (s.pend_slot == `LAST_SLOT) begin
                next_s.ctl[`CTL_FLAG_BIT] = 1'b1; // [R5]
            end
        end

        // conversion sequencer
        case (s.phase)
            adc_seq_pkg::PH_IDLE: begin
                next_s.tick_cnt = 4'h0;
            end
            adc_seq_pkg::PH_ARM: begin
                if (e_tick) begin
                    next_s.phase = adc_seq_pkg::PH_SAMPLE; // [R6]
                    next_s.tick_cnt = 4'h0;
                end
            end
            adc_seq_pkg::PH_SAMPLE: begin
                if (conv_tick) begin
                    if (s.tick_cnt == `SAMPLE_TICKS - 4'h1) begin
                        next_s.phase = adc_seq_pkg::PH_COMPARE;
                        next_s.sar = `SAR_START;
                        next_s.bit_idx = `SAR_MSB;
                        next_s.tick_cnt = 4'h0;
                    end else begin
                        next_s.tick_cnt = s.tick_cnt + 4'h1;
                    end
                end
            end
            adc_seq_pkg::PH_COMPARE: begin
                if (conv_tick) begin
                    // comparator is looked at only on the tick, a quiet moment
                    if (!comparator_in) begin
                        next_s.sar[s.bit_idx] = 1'b0; // [R7] [R10]
                    end
                    if (s.bit_idx == 3'h0) begin
                        next_s.pend_valid = 1'b1;
                        next_s.pend_slot = s.slot;
                        next_s.pend_data = comparator_in ? s.sar : (s.sar & 8'hfe);
                        next_s.slot = s.slot + 2'h1; // [R17] [R19]
                        if (s.slot == `LAST_SLOT && !repeat_mode) begin
                            next_s.phase = adc_seq_pkg::PH_IDLE; // [R4] [R16] [R18]
                        end else begin
                            next_s.phase = adc_seq_pkg::PH_SAMPLE; // [R4]
                        end
                    end else begin
                        next_s.bit_idx = s.bit_idx - 3'h1;
                        next_s.sar[s.bit_idx - 3'h1] = 1'b1;
                    end
                end
            end
            default: begin
                next_s.phase = adc_seq_pkg::PH_IDLE;
            end
        endcase

        // control/status write: abort, clear flag, arm new sequence
        if (ctl_write) begin
            next_s.ctl = wr_data_in & `CTL_WR_MASK; // [R20] [R22]
            next_s.pend_valid = 1'b0; // [R21]
            next_s.slot = 2'h0;
            next_s.tick_cnt = 4'h0;
            next_s.phase = adc_seq_pkg::PH_ARM; // [R6] [R21]
        end

        // options write with time-protected bits
        if (opt_write) begin
            if (prot_open) begin
                next_s.opt = wr_data_in; // [R11]
                if (!special_mode_in) begin
                    next_s.prot_used = 1'b1; // [R11]
                end
            end else begin
                next_s.opt = (wr_data_in & ~`OPT_PROT_MASK) | (s.opt & `OPT_PROT_MASK); // [R11]
            end
        end

        if (next_s.opt[`OPT_CLOCK_MONITOR_FORCE_BIT]) begin
            next_s.force_latched = 1'b1; // [R14]
        end

        // unpowered converter does nothing; a start written while unpowered is dropped and stays idle
        if (!s.opt[`OPT_PU_BIT] && s.phase != adc_seq_pkg::PH_IDLE && !ctl_write) begin
            next_s.phase = adc_seq_pkg::PH_IDLE; // [R8]
        end
        if (!s.opt[`OPT_PU_BIT] && ctl_write) begin
            next_s.phase = adc_seq_pkg::PH_IDLE; // [R8]
        end

        // read data, valid only in the cycle after the strobe
        next_s.rd_data = 8'h00;
        if (rd_in) begin
            if (addr_in == `CTL_ADDR) begin
                next_s.rd_data = s.ctl; // [R20]
            end else if (addr_in >= `RES1_ADDR && addr_in <= `RES4_ADDR) begin
                next_s.rd_data = s.results[2'(addr_in - `RES1_ADDR)]; // [R1]
            end else if (addr_in == `OPT_ADDR) begin
                next_s.rd_data = s.opt;
            end else begin
                next_s.rd_data = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s.phase <= adc_seq_pkg::PH_IDLE;
            s.ctl <= 8'h00;
            s.results <= '0;
            s.opt <= `OPT_RESET;
            s.force_latched <= 1'b0;
            s.win_cnt <= 7'h00;
            s.prot_used <= 1'b0;
            s.slot <= 2'h0;
            s.tick_cnt <= 4'h0;
            s.bit_idx <= 3'h0;
            s.sar <= 8'h00;
            s.pend_valid <= 1'b0;
            s.pend_slot <= 2'h0;
            s.pend_data <= 8'h00;
            s.ediv <= 8'h00;
            s.rd_data <= 8'h00;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_data_out = s.rd_data;
    assign e_tick_out = e_tick;
    assign sequence_complete_flag_out = s.ctl[`CTL_FLAG_BIT];

    assign analog_ctl_out.channel = chan; // [R15]
    assign analog_ctl_out.sample = (s.phase == adc_seq_pkg::PH_SAMPLE);
    assign analog_ctl_out.dac_code = s.sar;
    assign analog_ctl_out.powered = s.opt[`OPT_PU_BIT]; // [R8]
    assign analog_ctl_out.use_rc_clock = s.opt[`OPT_CONV_CLOCK_SELECT_BIT]; // [R3]

    assign sys_opts_out.irq_falling_edge = s.opt[`OPT_IRQ_EDGE_SELECT_BIT]; // [R12]
    assign sys_opts_out.startup_delay_enable = s.opt[`OPT_DLY_BIT]; // [R13]
    assign sys_opts_out.clock_monitor_on = s.opt[`OPT_CME_BIT] | s.force_latched; // [R14]
    assign sys_opts_out.watchdog_rate_select = s.opt[`OPT_RATE_MSB:0]; // [R11]

endmodule : adc_conversion_sequencer

`default_nettype wire

// *** tb/adc_seq_sva.sv ***
// Purpose: port assertions for the sequencer
// Assumes: E_DIV as on the instance
// Notes: bound at the foot
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defs.svh"
module adc_seq_checker #(
    parameter int E_DIV = 4
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rd_data_out,
    input wire adc_seq_pkg::analog_ctl_t analog_ctl_out,
    input wire logic e_tick_out,
    input wire logic sequence_complete_flag_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    logic [7:0] gap;
    logic seen;
    // latest start: a full e clock period after the write, plus the step into sampling
    localparam int START_MAX = E_DIV + 1;
    // ----
    // e tick spacing, counted since the last tick
    // ----
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gap <= 8'h00;
            seen <= 1'b0;
        end else begin
            gap <= e_tick_out ? 8'h00 : gap + 8'h01;
            seen <= seen | e_tick_out;
        end
    end
    sequence ctl_write;
        wr_in && addr_in == `CTL_ADDR;
    endsequence
    sequence quiet7;
        !wr_in [*7];
    endsequence
    chk_rd_idle: assert property (!$past(rd_in) |-> rd_data_out == 8'h00)
        else $error("read data not idle");
    chk_bit6_zero: assert property (rd_in && addr_in == `CTL_ADDR |=> !rd_data_out[6])
        else $error("control bit 6 not zero");
    chk_flag_read: assert property (rd_in && addr_in == `CTL_ADDR |=>
        rd_data_out[7] == $past(sequence_complete_flag_out)) else $error("flag read wrong");
    chk_flag_clear: assert property (ctl_write |=> !sequence_complete_flag_out)
        else $error("flag not cleared by write");
    chk_flag_hold: assert property (sequence_complete_flag_out && !wr_in |=>
        sequence_complete_flag_out) else $error("flag dropped");
    chk_commit_quiet: assert property ($rose(sequence_complete_flag_out) |-> !$past(rd_in))
        else $error("flag set beside a read");
    chk_start_soon: assert property (ctl_write ##0 (analog_ctl_out.powered &&
        !analog_ctl_out.use_rc_clock) |-> ##[1:START_MAX] analog_ctl_out.sample)
        else $error("late start");
    chk_e_period: assert property (e_tick_out && seen |-> gap == 8'(E_DIV - 1))
        else $error("e tick spacing wrong");
    chk_sample_hold: assert property (($rose(analog_ctl_out.sample) && !wr_in) ##1 quiet7 |->
        analog_ctl_out.sample) else $error("sample phase too short");
    chk_unpowered_idle: assert property (!analog_ctl_out.powered [*2] |->
        !analog_ctl_out.sample) else $error("sampling while unpowered");
endmodule : adc_seq_checker
bind adc_conversion_sequencer adc_seq_checker #(.E_DIV(E_DIV)) u_chk (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .analog_ctl_out(analog_ctl_out),
    .e_tick_out(e_tick_out), .sequence_complete_flag_out(sequence_complete_flag_out));
`default_nettype wire

// *** tb/adc_front_model.sv ***
// Purpose: mux and comparator model
// Assumes: comparator high keeps the trial bit
// Notes: unpowered output wobbles, never a clean level
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
    input wire logic core_clk_in,
    input wire adc_seq_pkg::analog_ctl_t analog_ctl_in,
    output logic comparator_out
);
    logic wobble = 1'b0;
    logic [7:0] level;
    always_ff @(posedge core_clk_in) begin
        wobble <= ~wobble;
    end
    always_comb begin
        case (analog_ctl_in.channel)
            4'hc: level = 8'hff;
            4'hd: level = 8'h00;
            4'he: level = 8'h80;
            default: level = analog_ctl_in.channel * 8'h11;
        endcase
        comparator_out = analog_ctl_in.powered ? (level >= analog_ctl_in.dac_code) : wobble;
    end
endmodule : adc_front_model
`default_nettype wire

// *** tb/adc_conversion_sequencer_bench.sv ***
// Purpose: bench for the converter sequencer
// Assumes: E_DIV 4, levels from adc_front_model
// Notes: the 100us settle wait dominates run time
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defs.svh"
module adc_conversion_sequencer_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic spec = 1'b0;
    logic rc = 1'b0;
    logic [2:0] rcn = 3'h0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wd = 8'h00;
    logic [7:0] rdat;
    logic [7:0] d;
    logic comp;
    logic flag;
    adc_seq_pkg::analog_ctl_t actl;
    adc_seq_pkg::sys_opts_t opts;
    int err_count = 0;
    int cmp_count = 0;
    adc_conversion_sequencer #(.E_DIV(4)) u_dut (.core_clk_in(clk), .nrst_in(nrst),
        .addr_in(addr), .wr_data_in(wd), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat),
        .special_mode_in(spec), .rc_tick_in(rc), .comparator_in(comp), .analog_ctl_out(actl),
        .sys_opts_out(opts), .e_tick_out(), .sequence_complete_flag_out(flag));
    adc_front_model u_front (.core_clk_in(clk), .analog_ctl_in(actl), .comparator_out(comp));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        rcn <= (rcn == 3'h4) ? 3'h0 : rcn + 3'h1;
        rc <= (rcn == 3'h4);
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdat;
    endtask : rd_reg
    task automatic wait_flag();
        int n;
        n = 0;
        while (flag !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        check({7'h0, flag}, 8'h01);
    endtask : wait_flag
    task automatic res4(input logic [31:0] exp);
        for (int i = 0; i < 4; i++) begin
            rd_reg(`RES1_ADDR + 8'(i));
            check(d, exp[8*i +: 8]);
        end
    endtask : res4
    task automatic t_opts();
        rd_reg(`OPT_ADDR);
        check(d, `OPT_RESET);
        wr_reg(`OPT_ADDR, 8'ha4);
        rd_reg(`OPT_ADDR);
        check(d, 8'ha4);
        check({5'h0, opts.irq_falling_edge, opts.startup_delay_enable, opts.clock_monitor_on},
            8'h05);
        wr_reg(`OPT_ADDR, 8'h83);
        rd_reg(`OPT_ADDR);
        check(d, 8'ha4);
        check({6'h0, opts.watchdog_rate_select}, 8'h00);
        check({6'h0, opts.clock_monitor_on, actl.powered}, 8'h03);
        repeat (12500) @(posedge clk);
    endtask : t_opts
    task automatic t_single();
        wr_reg(`CTL_ADDR, 8'h02);
        rd_reg(`CTL_ADDR);
        check(d, 8'h02);
        wait_flag();
        res4(32'h22222222);
        rd_reg(`CTL_ADDR);
        check(d, 8'h82);
        wr_reg(`RES1_ADDR, 8'h55);
        rd_reg(`RES1_ADDR);
        check(d, 8'h22);
        rd_reg(8'h3f);
        check({d[7:1], actl.sample}, 8'h00);
    endtask : t_single
    task automatic t_multi();
        wr_reg(`CTL_ADDR, 8'h1d);
        wait_flag();
        res4(32'hff8000ff);
    endtask : t_multi
    task automatic t_abort();
        wr_reg(`CTL_ADDR, 8'h13);
        repeat (200) @(posedge clk);
        wr_reg(`CTL_ADDR, 8'h05);
        check({7'h0, flag}, 8'h00);
        wait_flag();
        res4(32'h55555555);
    endtask : t_abort
    task automatic t_repeat();
        int n;
        wr_reg(`OPT_ADDR, 8'he4);
        check({7'h0, actl.use_rc_clock}, 8'h01);
        wr_reg(`CTL_ADDR, 8'h23);
        wait_flag();
        res4(32'h33333333);
        n = 0;
        while (actl.sample !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        check({6'h0, actl.sample, flag}, 8'h03);
        wr_reg(`CTL_ADDR, 8'h33);
        wait_flag();
        res4(32'h33221100);
        wr_reg(`OPT_ADDR, 8'h64);
        wr_reg(`CTL_ADDR, 8'h02);
        repeat (100) @(posedge clk);
        check({5'h0, actl.powered, actl.sample, flag}, 8'h00);
        spec <= 1'b1;
        wr_reg(`OPT_ADDR, 8'h97);
        rd_reg(`OPT_ADDR);
        check(d, 8'h97);
        check({6'h0, opts.watchdog_rate_select}, 8'h03);
    endtask : t_repeat
    task automatic t_window();
        // second reset mid-run: force latch must drop, window must close after 64 cycles
        @(posedge clk);
        spec <= 1'b0;
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        check({6'h0, flag, opts.clock_monitor_on}, 8'h00);
        repeat (70) @(posedge clk);
        wr_reg(`OPT_ADDR, 8'hb7);
        rd_reg(`OPT_ADDR);
        check(d, 8'h90);
        check({3'h0, opts.irq_falling_edge, opts.startup_delay_enable, opts.clock_monitor_on,
            opts.watchdog_rate_select}, 8'h08);
    endtask : t_window
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_opts();
        t_single();
        t_multi();
        t_abort();
        t_repeat();
        t_window();
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule : adc_conversion_sequencer_bench
`default_nettype wire
